// ### sarspi_defs.svh
`ifndef SARSPI_DEFS_SVH
`define SARSPI_DEFS_SVH

// output data word and conversion result
`define SARSPI_WORD_W        20
`define SARSPI_RES_W         18
`define SARSPI_CMD_CLKS      5'd20
`define SARSPI_WORD_BITS     7'd20

// timing
`define SARSPI_CLK_NS        25
`define SARSPI_T_CONV_NS     300
`define SARSPI_CONV_CYC      ((`SARSPI_T_CONV_NS + `SARSPI_CLK_NS - 1) / `SARSPI_CLK_NS)

// command opcodes in bits [19:16]
`define SARSPI_OPC_RD        4'h9
`define SARSPI_OPC_WR        4'hA

// control register addresses
`define SARSPI_ADDR_IN_CTL   8'h01
`define SARSPI_ADDR_OUT_CTL  8'h02

// field positions
`define SARSPI_IN_MODE_LSB   0
`define SARSPI_OUT_WIDTH_LSB 2
`define SARSPI_OUT_DDR_BIT   4
`define SARSPI_OUT_SRC_BIT   6

// reset values
`define SARSPI_IN_CTL_RST    8'h00
`define SARSPI_OUT_CTL_RST   8'h00

`endif

// ### sarspi_pkg.sv
package sarspi_pkg;

  typedef enum logic [1:0] {
    SARSPI_W_SINGLE  = 2'b00,
    SARSPI_W_SINGLE1 = 2'b01,
    SARSPI_W_DUAL    = 2'b10,
    SARSPI_W_QUAD    = 2'b11
  } sarspi_width_e;

  typedef enum logic {
    SARSPI_CV_IDLE = 1'b0,
    SARSPI_CV_BUSY = 1'b1
  } sarspi_conv_e;

  typedef logic [19:0] sarspi_word_t;

endpackage

// ### sarspi_link.sv
`timescale 1ns/10ps
`include "sarspi_defs.svh"

module sarspi_link (
  input  wire logic               link_clk,
  input  wire logic               frame_rst,
  input  wire logic               rst_b,
  input  wire logic               sdi,
  output sarspi_pkg::sarspi_word_t in_word_ff,
  output logic [4:0]              cap_cnt_ff,
  output logic                    cap_on_ff,
  output logic [4:0]              launch_cnt_ff,
  output logic                    launch_on_ff,
  output logic                    frame_tgl_ff
);
  import sarspi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // frame-local flags, cleared while chip select is high
  always_ff @(posedge link_clk or posedge frame_rst) begin
    if (frame_rst) begin
      cap_on_ff <= 1'b0;
    end else begin
      cap_on_ff <= 1'b1;
    end
  end

  always_ff @(negedge link_clk or posedge frame_rst) begin
    if (frame_rst) begin
      launch_on_ff <= 1'b0;
    end else begin
      launch_on_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word and count survive chip select rising so the ref side can decode
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_word_ff   <= '0;
      cap_cnt_ff   <= 5'h00;
      frame_tgl_ff <= 1'b0;
    end else if (!frame_rst) begin
      // a mode change folds the idle clock into an edge outside any frame;
      // that edge must not count as a frame or the toggle pairing breaks
      if (!cap_on_ff) begin
        in_word_ff   <= {19'h00000, sdi};                          // see RQ18
        cap_cnt_ff   <= 5'h01;
        frame_tgl_ff <= ~frame_tgl_ff;
      end else begin
        in_word_ff <= {in_word_ff[18:0], sdi};                     // see RQ18
        if (cap_cnt_ff != 5'h1F) begin
          cap_cnt_ff <= cap_cnt_ff + 5'h01;
        end
      end
    end
  end

  // launch edges are opposite the capture edges
  always_ff @(negedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      launch_cnt_ff <= 5'h00;
    end else if (!launch_on_ff) begin
      launch_cnt_ff <= 5'h01;                                      // see RQ11
    end else if (launch_cnt_ff != 5'h1F) begin
      launch_cnt_ff <= launch_cnt_ff + 5'h01;
    end
  end

endmodule

// ### sarspi_top.sv
`timescale 1ns/10ps
`include "sarspi_defs.svh"

// Contract
// RQ1 - host sets throughput by spacing conversion-start rising edges
// RQ2 - result ready after conversion time, loaded for output at chip-select fall
// RQ3 - host fetches result before the next conversion completes
// RQ4 - host keeps digital pins quiet around each sampling instant
// RQ5 - early transfer window spans conversion end to next quiet window
// RQ6 - late transfer window follows the next aperture window
// RQ7 - frames may span both windows avoiding quiet windows
// RQ8 - single-lane read needs 18 clocks, setting the minimum clock rate
// RQ9 - longer reads only lengthen response and maybe cycle time
// RQ10 - response time is conversion or cycle time plus read time
// RQ11 - launch and capture happen on opposite serial clock edges
// RQ12 - wider output lanes and double rate, usable together
// RQ13 - source-synchronous mode drives its own clock on the strobe pin
// RQ14 - four single-lane write modes selected by input clocking field
// RQ15 - host sends exactly 20 clocks in a command frame
// RQ16 - after reset, idle-low rising-capture single-lane mode
// RQ17 - input clocking field change applies to every following frame
// RQ18 - under 20 clocks is no-op; else last 20 bits are command
// RQ19 - chip-select rise tri-states lanes and hands word to decoder
// RQ20 - strobe stays low for whole frame in plain serial modes
// RQ21 - each frame returns latest completed result at its start; the frame after a read command returns register data instead

module sarspi_top (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic                    sclk,
  input  wire logic                    cs_b,
  input  wire logic                    sdi,
  input  wire logic                    conversion_start_pin,
  input  wire logic [`SARSPI_RES_W-1:0] adc_result,
  output logic [3:0]                   sdo,
  output logic [3:0]                   sdo_oe,
  output logic                         ready_strobe_pin,
  output logic                         conv_busy,
  output logic [7:0]                   in_ctl_q,
  output logic [7:0]                   out_ctl_q
);
  import sarspi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] lane_count(input logic [1:0] w);
    unique case (sarspi_width_e'(w))
      SARSPI_W_QUAD:   return 3'd4;
      SARSPI_W_DUAL:   return 3'd2;
      SARSPI_W_SINGLE,
      SARSPI_W_SINGLE1: return 3'd1;
    endcase
  endfunction

  function automatic logic [3:0] lanes_out(input sarspi_word_t w,
                                           input logic [6:0] pos);
    logic [6:0] idx;
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 4; k++) begin
      idx = pos + 7'(k);
      if (idx < `SARSPI_WORD_BITS) begin
        r[k] = w[5'(7'd19 - idx)];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [4:0] CONV_LAST = 5'(`SARSPI_CONV_CYC - 1);

  logic [7:0]         in_ctl_ff;
  logic [7:0]         out_ctl_ff;
  logic               cs_s1_ff;
  logic               cs_s2_ff;
  logic               cs_d_ff;
  logic               cnv_s1_ff;
  logic               cnv_s2_ff;
  logic               cnv_d_ff;
  logic               tgl_s1_ff;
  logic               tgl_s2_ff;
  logic               tgl_seen_ff;
  sarspi_conv_e       conv_st_ff;
  logic [4:0]         conv_cnt_ff;
  logic [17:0]        latest_ff;
  sarspi_word_t       word_ff;
  logic               rd_pend_ff;
  logic [7:0]         rd_data_ff;
  logic               ready_ff;
  logic               src_clk_ff;
  logic [6:0]         src_cnt_ff;
  sarspi_word_t       in_word;
  logic [4:0]         cap_cnt;
  logic               cap_on;
  logic [4:0]         launch_cnt;
  logic               launch_on;
  logic               frame_tgl;
  logic               cap_fall;
  logic               cpha1;
  logic               link_clk;
  logic               frame_rst;
  logic               out_src;
  logic               out_ddr;
  logic [2:0]         lanes;
  logic               decode;
  logic               cmd_ok;
  logic [6:0]         spi_pos;

  assign in_ctl_q  = in_ctl_ff;
  assign out_ctl_q = out_ctl_ff;
  assign out_src   = out_ctl_ff[`SARSPI_OUT_SRC_BIT];
  assign out_ddr   = out_ctl_ff[`SARSPI_OUT_DDR_BIT];
  assign lanes     = lane_count(out_ctl_ff[`SARSPI_OUT_WIDTH_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // link clock: serial clock folded so capture is always its rising edge.
  // mode only changes while chip select is high, so no runt edge in a frame
  assign cap_fall  = in_ctl_ff[`SARSPI_IN_MODE_LSB] ^
                     in_ctl_ff[`SARSPI_IN_MODE_LSB + 1];           // see RQ14
  assign cpha1     = in_ctl_ff[`SARSPI_IN_MODE_LSB];
  assign link_clk  = sclk ^ cap_fall;
  assign frame_rst = cs_b | ~rst_b;

  sarspi_link u_link (
    .link_clk      (link_clk),
    .frame_rst     (frame_rst),
    .rst_b         (rst_b),
    .sdi           (sdi),
    .in_word_ff    (in_word),
    .cap_cnt_ff    (cap_cnt),
    .cap_on_ff     (cap_on),
    .launch_cnt_ff (launch_cnt),
    .launch_on_ff  (launch_on),
    .frame_tgl_ff  (frame_tgl)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1_ff  <= 1'b1;
      cs_s2_ff  <= 1'b1;
      cs_d_ff   <= 1'b1;
      cnv_s1_ff <= 1'b0;
      cnv_s2_ff <= 1'b0;
      cnv_d_ff  <= 1'b0;
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff  <= cs_b;
      cs_s2_ff  <= cs_s1_ff;
      cs_d_ff   <= cs_s2_ff;
      cnv_s1_ff <= conversion_start_pin;
      cnv_s2_ff <= cnv_s1_ff;
      cnv_d_ff  <= cnv_s2_ff;
      tgl_s1_ff <= frame_tgl;
      tgl_s2_ff <= tgl_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion timer; a start edge during a conversion is ignored
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_st_ff  <= SARSPI_CV_IDLE;
      conv_cnt_ff <= 5'h00;
      latest_ff   <= '0;
    end else begin
      unique case (conv_st_ff)
        SARSPI_CV_IDLE: begin
          if (cnv_s2_ff && !cnv_d_ff) begin                        // see RQ1
            conv_st_ff  <= SARSPI_CV_BUSY;
            conv_cnt_ff <= 5'h00;
          end
        end
        SARSPI_CV_BUSY: begin
          if (conv_cnt_ff == CONV_LAST) begin
            conv_st_ff <= SARSPI_CV_IDLE;
            latest_ff  <= adc_result;                              // see RQ2
          end else begin
            conv_cnt_ff <= conv_cnt_ff + 5'h01;
          end
        end
      endcase
    end
  end

  assign conv_busy = (conv_st_ff == SARSPI_CV_BUSY);              // see RQ10

  ////////////////////////////////////////////////////////////////////////////
  // output word follows the latest result only between frames, so the
  // frame sees what was current at its chip-select fall (sync lag applies)
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_ff <= '0;
    end else if (cs_s2_ff) begin
      word_ff <= rd_pend_ff ? {rd_data_ff, 12'h000}
                            : {latest_ff, 2'b00};                  // see RQ21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode, two ref cycles after chip-select rise
  assign decode = cs_s2_ff && !cs_d_ff;                             // see RQ19
  assign cmd_ok = (tgl_s2_ff != tgl_seen_ff) &&
                  (cap_cnt >= `SARSPI_CMD_CLKS);                    // see RQ18

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_ctl_ff  <= `SARSPI_IN_CTL_RST;                            // see RQ16
      out_ctl_ff <= `SARSPI_OUT_CTL_RST;
    end else if (decode && cmd_ok && in_word[19:16] == `SARSPI_OPC_WR) begin
      if (in_word[15:8] == `SARSPI_ADDR_IN_CTL) begin
        in_ctl_ff <= in_word[7:0];                                 // see RQ17
      end
      if (in_word[15:8] == `SARSPI_ADDR_OUT_CTL) begin
        out_ctl_ff <= in_word[7:0];                                // see RQ12
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_ff  <= 1'b0;
      rd_data_ff  <= 8'h00;
      tgl_seen_ff <= 1'b0;
    end else if (decode) begin
      tgl_seen_ff <= tgl_s2_ff;
      rd_pend_ff  <= cmd_ok && in_word[19:16] == `SARSPI_OPC_RD;
      if (in_word[15:8] == `SARSPI_ADDR_IN_CTL) begin
        rd_data_ff <= in_ctl_ff;
      end else if (in_word[15:8] == `SARSPI_ADDR_OUT_CTL) begin
        rd_data_ff <= out_ctl_ff;
      end else begin
        rd_data_ff <= 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_ff <= 1'b1;
    end else if (!cs_s2_ff) begin
      ready_ff <= 1'b0;
    end else if (decode) begin
      ready_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source-synchronous read: strobe at half the ref rate, data moves as
  // strobe falls so the host captures on its rise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_clk_ff <= 1'b0;
      src_cnt_ff <= 7'h00;
    end else if (!out_src || cs_s2_ff) begin
      src_clk_ff <= 1'b0;
      src_cnt_ff <= 7'h00;
    end else if (src_cnt_ff < `SARSPI_WORD_BITS) begin
      src_clk_ff <= ~src_clk_ff;                                   // see RQ13
      if (src_clk_ff) begin
        src_cnt_ff <= src_cnt_ff + 7'(lanes);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial position: mode 0/2 shows the msb at chip-select fall, mode 1/3
  // on the first launch edge; double rate also steps on capture edges
  always_comb begin
    logic [5:0] steps;
    steps = 6'(launch_on ? launch_cnt : 5'h00);
    if (cpha1 && launch_on) begin
      steps = steps - 6'h01;                                       // see RQ11
    end
    if (out_ddr && cap_on) begin
      steps = steps + 6'(cap_cnt);                                 // see RQ12
    end
    spi_pos = 7'(steps * 6'(lanes));
  end

  assign sdo    = out_src ? lanes_out(word_ff, src_cnt_ff)
                          : lanes_out(word_ff, spi_pos);
  assign sdo_oe = cs_b         ? 4'h0 :
                  (lanes == 3'd4) ? 4'hF :
                  (lanes == 3'd2) ? 4'h3 : 4'h1;                    // see RQ19
  assign ready_strobe_pin = out_src ? src_clk_ff
                                    : (cs_b & ready_ff);           // see RQ20

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_src_open;
    $fell(cs_s2_ff) && out_src;
  endsequence

  sequence s_cmd_taken;
    decode && cmd_ok && in_word[19:16] == `SARSPI_OPC_WR &&
      in_word[15:8] == `SARSPI_ADDR_IN_CTL;
  endsequence

  a_strobe_low_frame: assert property ( // see RQ20
    !out_src && !cs_s1_ff && !cs_s2_ff |-> !ready_strobe_pin)
    else $error("strobe high inside a serial frame");

  a_lanes_tristate: assert property ( // see RQ19
    cs_b |-> sdo_oe == 4'h0)
    else $error("data lanes driven outside a frame");

  a_conv_latch_time: assert property ( // see RQ2
    $rose(conv_busy) |-> conv_busy[*8] ##1 conv_busy[*4] ##1
      (!conv_busy && latest_ff == $past(adc_result)))
    else $error("result not latched after conversion time");

  a_word_frozen: assert property ( // see RQ21
    !cs_s2_ff && !$past(cs_s2_ff) |-> $stable(word_ff))
    else $error("output word changed inside a frame");

  a_mode_write: assert property ( // see RQ17
    s_cmd_taken |=> in_ctl_ff == $past(in_word[7:0]) ##1 $stable(in_ctl_ff))
    else $error("input mode write not applied");

  a_short_nop: assert property ( // see RQ18
    decode && !cmd_ok |=> $stable(in_ctl_ff) && $stable(out_ctl_ff)
      && !rd_pend_ff)
    else $error("short frame changed state");

  a_mode_steady: assert property ( // see RQ14
    !decode |=> $stable(in_ctl_ff))
    else $error("input mode changed without a command");

  a_src_strobe: assert property ( // see RQ13
    s_src_open |-> ##[1:2] $rose(ready_strobe_pin))
    else $error("source strobe did not start");

  a_ready_back: assert property ( // see RQ19
    decode |=> ready_ff [*2])
    else $error("ready not restored after decode");

endmodule

// ### sarspi_host.sv
`timescale 1ns/10ps
module sarspi_host (
  output logic            sclk,
  output logic            cs_b,
  output logic            sdi,
  input  wire logic [3:0] sdo,
  input  wire logic [3:0] sdo_oe,
  input  wire logic       ready_strobe_pin
);
  logic [1:0] cur_mode;

  initial begin
    sclk     = 1'b0;
    cs_b     = 1'b1;
    sdi      = 1'b0;
    cur_mode = 2'b00;
  end

  //////////////////////////////////////////////////////////////////////////
  // 12 ns serial period; outside frames the clock only moves to a new idle level
  task automatic frame(input int nclk, input logic [19:0] cmd,
                       output logic [19:0] rd, output logic [3:0] oe,
                       output logic rdy, output logic ok);
    int   k;
    logic cap_first;
    cap_first = ~cur_mode[0];
    rd        = '0;
    ok        = 1'b0;
    sclk      = cur_mode[1];
    // idle level settles before the frame opens, never with chip select
    #25;
    cs_b      = 1'b0;
    #100;
    oe  = sdo_oe;
    rdy = ready_strobe_pin;
    for (k = 0; k < nclk; k++) begin
      if (!cap_first) begin
        sclk = ~sclk;
      end
      // filler first, so the command sits in the last 20 clocks
      sdi = (k >= nclk - 20) ? cmd[nclk - 1 - k] : k[0];
      #6;
      if (k < 20) begin
        rd[19 - k] = sdo[0];
      end
      sclk = ~sclk;
      #6;
      if (cap_first) begin
        sclk = ~sclk;
      end
    end
    #6;
    cs_b = 1'b1;
    // a released line must not keep showing the last bit
    sdi  = ~sdi;
    for (k = 0; k < 40 && !ok; k++) begin
      #25;
      ok = (ready_strobe_pin === 1'b1) && (sdo_oe === 4'h0);
    end
    #100;
  endtask
endmodule

// ### sar_adc_frame_scheduling_spi_tb_top.sv
`timescale 1ns/10ps
`include "sarspi_defs.svh"
module sar_adc_frame_scheduling_spi_tb_top;
  import sarspi_pkg::*;
  logic        ref_clk;
  logic        rst_b;
  logic        sclk;
  logic        cs_b;
  logic        sdi;
  logic        conversion_start_pin;
  logic [17:0] adc_result;
  logic [17:0] r;
  logic [3:0]  sdo;
  logic [3:0]  sdo_oe;
  logic        ready_strobe_pin;
  logic        conv_busy;
  logic [7:0]  in_ctl_q;
  logic [7:0]  out_ctl_q;
  int          n_mismatch;
  int          samples_checked;
  int          cycles;
  int          m_in;
  int          m_out;
  int          m_result;
  int          m_pend;
  int          m_pend_v;
  int          i;

  sarspi_top DUT (
    .ref_clk              (ref_clk),
    .rst_b                (rst_b),
    .sclk                 (sclk),
    .cs_b                 (cs_b),
    .sdi                  (sdi),
    .conversion_start_pin (conversion_start_pin),
    .adc_result           (adc_result),
    .sdo                  (sdo),
    .sdo_oe               (sdo_oe),
    .ready_strobe_pin     (ready_strobe_pin),
    .conv_busy            (conv_busy),
    .in_ctl_q             (in_ctl_q),
    .out_ctl_q            (out_ctl_q)
  );

  sarspi_host host (
    .sclk             (sclk),
    .cs_b             (cs_b),
    .sdi              (sdi),
    .sdo              (sdo),
    .sdo_oe           (sdo_oe),
    .ready_strobe_pin (ready_strobe_pin)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // conversion with the busy length counted in ref_clk cycles
  task automatic conv(input logic [17:0] val);
    int k;
    @(posedge ref_clk);
    adc_result           <= val;
    conversion_start_pin <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (conv_busy !== 1'b1 && k < 8);
    k = 0;
    while (conv_busy === 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check(k, `SARSPI_CONV_CYC);
    m_result = val;
    @(posedge ref_clk);
    conversion_start_pin <= 1'b0;
  endtask

  // one frame, checked against the model, then the model steps
  task automatic xfer(input int nclk, input logic [19:0] cmd);
    logic [19:0] rd;
    logic [3:0]  oe;
    logic        rdy;
    logic        ok;
    int          exp;
    int          n;
    int          lanes;
    exp   = m_pend_v ? (m_pend << 12) : (m_result << 2);
    n     = (nclk < 20) ? nclk : 20;
    lanes = (m_out[3:2] == 3) ? 'hF : (m_out[3:2] == 2) ? 'h3 : 'h1;
    host.frame(nclk, cmd, rd, oe, rdy, ok);
    // wide lanes: the read data is not judged
    if (lanes == 1) begin
      check(rd >> (20 - n), exp >> (20 - n));
    end
    check(oe, lanes);
    check(rdy, 0);
    check(ok, 1);
    m_pend_v = 0;
    if (nclk >= 20 && cmd[15:8] == 8'h01 && cmd[19:16] == 4'hA) begin
      m_in = cmd[7:0];
    end
    if (nclk >= 20 && cmd[15:8] == 8'h02 && cmd[19:16] == 4'hA) begin
      m_out = cmd[7:0];
    end
    if (nclk >= 20 && cmd[19:16] == 4'h9) begin
      m_pend_v = 1;
      m_pend   = (cmd[15:8] == 8'h01) ? m_in : m_out;
    end
    check(in_ctl_q, m_in);
    check(out_ctl_q, m_out);
    host.cur_mode = m_in[1:0];
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(55096));
    rst_b                = 1'b0;
    conversion_start_pin = 1'b0;
    adc_result           = 18'h00000;
    n_mismatch           = 0;
    samples_checked      = 0;
    cycles               = 0;
    m_in                 = 0;
    m_out                = 0;
    m_result             = 0;
    m_pend               = 0;
    m_pend_v             = 0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(in_ctl_q, 0);
    check(out_ctl_q, 0);
    check(conv_busy, 0);
    check(ready_strobe_pin, 1);
    for (i = 0; i < 3; i++) begin
      r = $urandom;
      conv(r);
      xfer(18, 20'h00000);
    end
    xfer(19, {4'hA, 8'h01, 8'h03});
    // walk every clocking mode; the filler makes long frames awkward
    for (i = 1; i < 5; i++) begin
      xfer(25, {4'hA, 8'h01, 6'h00, i[1:0]});
      xfer(20, {4'h9, 8'h01, 8'h00});
      r = $urandom;
      conv(r);
      xfer(20, 20'h00000);
    end
    // a frame opened mid-conversion still sees the older result
    r = $urandom;
    fork
      conv(r);
      xfer(18, 20'h00000);
    join
    xfer(18, 20'h00000);
    xfer(20, {4'hA, 8'h02, 8'h0C});
    xfer(5, 20'h00000);
    xfer(20, {4'hA, 8'h02, 8'h08});
    xfer(20, {4'hA, 8'h02, 8'h00});
    xfer(20, {4'h9, 8'h02, 8'h00});
    xfer(20, {4'hA, 8'h01, 8'h02});
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
    check(in_ctl_q, 0);
    check(out_ctl_q, 0);
    report_and_stop();
  end
endmodule
